// ===== slm_pkg.sv
// package for the shared transceiver lane selection block
// assumes a single 50 MHz clock and an avalon-mm register master
`default_nettype none
package slm_pkg;
	// register word byte addresses
	localparam logic [3:0] ADDR_LANE_SEL  = 4'h0;
	localparam logic [3:0] ADDR_ETH_CFG   = 4'h4;
	localparam logic [3:0] ADDR_HOTPLUG   = 4'h8;
	localparam logic [3:0] ADDR_STATUS    = 4'hc;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

	// lane_sel fields
	localparam int SEL_A_LSB = 0;
	localparam int SEL_B_LSB = 2;
	localparam int SEL_C_LSB = 4;
	localparam int LOCK_BIT  = 8;
	// eth_cfg fields
	localparam int ETH_MODE_LSB  = 0;
	localparam int ETH_MAC_BIT   = 2;
	localparam int ETH_SLOT_LSB  = 4;
	localparam int ETH_SPD_LSB   = 8;
	// hotplug field
	localparam int HP_SEL_LSB    = 0;
	localparam int HP_PWR_BIT    = 4;
	// storage speed field, one two-bit code per controller
	localparam int SPD_LSB       = 16;

	localparam int NUM_LANES     = 3;
	localparam int PM_MAX_DRIVES = 5;
	localparam int QUAD_SLOTS    = 4;
	localparam int MAX_MACS      = 2;

	// blink timing
	localparam int  BLINK_MS      = 50;
	localparam int  CLK_KHZ       = 50_000;
	localparam int  BLINK_CYCLES  = BLINK_MS * CLK_KHZ;

	typedef enum logic [1:0] {
		OWN_STORAGE = 2'b00,
		OWN_ALT1    = 2'b01,
		OWN_ALT2    = 2'b10,
		OWN_NONE    = 2'b11
	} slm_owner_t;

	typedef enum logic [1:0] {
		ETH_OFF    = 2'b00,
		ETH_SINGLE = 2'b01,
		ETH_QUAD   = 2'b10,
		ETH_RSVD   = 2'b11
	} slm_eth_mode_t;

	typedef enum logic [1:0] {
		SPD_1G5 = 2'b00,
		SPD_3G0 = 2'b01,
		SPD_6G0 = 2'b10,
		SPD_BAD = 2'b11
	} slm_spd_t;

	typedef enum logic [1:0] {
		ESPD_10   = 2'b00,
		ESPD_100  = 2'b01,
		ESPD_1000 = 2'b10,
		ESPD_BAD  = 2'b11
	} slm_espd_t;

	// which banks lose their parallel mac route
	typedef struct packed {
		logic bank_four_off;
		logic bank_five_off;
		logic bank_six_off;
	} slm_bank_t;

	// lane enables per serdes
	typedef struct packed {
		logic storage;
		logic alt1;
		logic alt2;
	} slm_lane_en_t;
endpackage
`default_nettype wire

// ===== slm_mux.sv
// shared transceiver lane selection, hot-plug sideband and lamp logic
// assumes registers are written by software before link bring-up
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`default_nettype none
module slm_mux #(
	parameter int BLINK_CYCLES = slm_pkg::BLINK_CYCLES
) (
	input  wire logic                      clk,
	input  wire logic                      reset_n,
	input  wire logic                      clk_en,
	// avalon-mm slave
	input  wire logic [3:0]                avs_address,
	input  wire logic                      avs_read,
	input  wire logic                      avs_write,
	input  wire logic [31:0]               avs_writedata,
	input  wire logic [3:0]                avs_byteenable,
	output logic [31:0]                    avs_readdata,
	output logic                           avs_waitrequest,
	// storage controller activity, one per controller
	input  wire logic [2:0]                storage_busy,
	// hot-plug sideband pins
	input  wire logic                      hotplug_presence_in,
	input  wire logic                      hotplug_switch_in,
	output logic                           hotplug_power_out,
	// per-controller sideband view
	output logic [2:0]                     storage_presence,
	output logic [2:0]                     storage_switch,
	input  wire logic [2:0]                storage_power_req,
	// lane enables
	output slm_pkg::slm_lane_en_t          serdes_a_en,
	output slm_pkg::slm_lane_en_t          serdes_b_en,
	output slm_pkg::slm_lane_en_t          serdes_c_en,
	output slm_pkg::slm_spd_t [2:0]        storage_speed,
	output logic [2:0]                     storage_pm_en,
	// ethernet pcs
	output logic                           quad_serial_route_zero,
	output logic                           quad_serial_route_one,
	output slm_pkg::slm_eth_mode_t         pcs_mode,
	output logic [3:0]                     quad_slot_en,
	output slm_pkg::slm_espd_t             pcs_port_speed,
	output logic                           ethernet_mac_a_serial,
	output logic                           ethernet_mac_b_serial,
	output slm_pkg::slm_bank_t             bank_off,
	output logic [2:0]                     activity_lamp
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [31:0] lane_sel_r;
	logic [31:0] eth_cfg_r;
	logic [31:0] hotplug_r;
	logic        rd_pend_r;
	logic        cfg_err_r;

	logic        wr_ok;
	logic        locked;
	logic [31:0] wmask;

	// the lamp counter needs at least two counts per phase
	if (BLINK_CYCLES < 2) begin : g_bad_blink
		$error("blink period too short");
	end

	assign locked = lane_sel_r[slm_pkg::LOCK_BIT];
	assign wmask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign wr_ok  = clk_en && avs_write;

	// ------------------------------------------------------------
	// bus slave: writes in zero wait, reads after one wait cycle
	// ------------------------------------------------------------
	// a frozen slave must not let a write slip past untaken
	assign avs_waitrequest = (avs_read && !rd_pend_r) ||
		((avs_read || avs_write) && !clk_en);

	always_ff @(posedge clk) begin
		if (!reset_n)
			rd_pend_r <= 1'b0;
		else if (clk_en)
			rd_pend_r <= avs_read && !rd_pend_r;
	end

	// lane ownership frozen once lock is set
	always_ff @(posedge clk) begin
		if (!reset_n)
			lane_sel_r <= 32'h0000_0000;
		else if (wr_ok && avs_address == slm_pkg::ADDR_LANE_SEL && !locked)
			lane_sel_r <= (lane_sel_r & ~wmask) | (avs_writedata & wmask);
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			eth_cfg_r <= 32'h0000_0000;
		else if (wr_ok && avs_address == slm_pkg::ADDR_ETH_CFG && !locked)
			eth_cfg_r <= (eth_cfg_r & ~wmask) | (avs_writedata & wmask);
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			hotplug_r <= 32'h0000_0000;
		else if (wr_ok && avs_address == slm_pkg::ADDR_HOTPLUG)
			hotplug_r <= (hotplug_r & ~wmask) | (avs_writedata & wmask);
	end

	// ------------------------------------------------------------
	// decode of owners
	// ------------------------------------------------------------
	slm_pkg::slm_owner_t own_a;
	slm_pkg::slm_owner_t own_b;
	slm_pkg::slm_owner_t own_c;
	slm_pkg::slm_eth_mode_t emode;
	logic        mac_b_sel;
	logic        pcs_on_b;
	logic        pcs_on_c;
	logic        pcs_conflict;

	assign own_a = slm_pkg::slm_owner_t'(lane_sel_r[slm_pkg::SEL_A_LSB +: 2]);
	assign own_b = slm_pkg::slm_owner_t'(lane_sel_r[slm_pkg::SEL_B_LSB +: 2]);
	assign own_c = slm_pkg::slm_owner_t'(lane_sel_r[slm_pkg::SEL_C_LSB +: 2]);
	assign emode = slm_pkg::slm_eth_mode_t'(
		eth_cfg_r[slm_pkg::ETH_MODE_LSB +: 2]);
	assign mac_b_sel = eth_cfg_r[slm_pkg::ETH_MAC_BIT];

	// pcs needs an active mode; b wins if both request it
	assign pcs_on_b = (emode == slm_pkg::ETH_SINGLE ||
		emode == slm_pkg::ETH_QUAD) && own_b == slm_pkg::OWN_ALT2;
	assign pcs_on_c = (emode == slm_pkg::ETH_SINGLE ||
		emode == slm_pkg::ETH_QUAD) && own_c == slm_pkg::OWN_ALT2
		&& !pcs_on_b;
	assign pcs_conflict = own_b == slm_pkg::OWN_ALT2 &&
		own_c == slm_pkg::OWN_ALT2;

	// ------------------------------------------------------------
	// lane enables, at most one set per transceiver, registered
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			serdes_a_en <= '0;
			serdes_b_en <= '0;
			serdes_c_en <= '0;
		end else if (clk_en) begin
			// serdes a has no second alternate
			serdes_a_en.storage <= own_a == slm_pkg::OWN_STORAGE;
			serdes_a_en.alt1    <= own_a == slm_pkg::OWN_ALT1;
			serdes_a_en.alt2    <= 1'b0;
			serdes_b_en.storage <= own_b == slm_pkg::OWN_STORAGE;
			serdes_b_en.alt1    <= own_b == slm_pkg::OWN_ALT1;
			serdes_b_en.alt2    <= pcs_on_b;
			serdes_c_en.storage <= own_c == slm_pkg::OWN_STORAGE;
			serdes_c_en.alt1    <= own_c == slm_pkg::OWN_ALT1;
			serdes_c_en.alt2    <= pcs_on_c;
		end
	end

	// ------------------------------------------------------------
	// storage speed and port multiplier
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < slm_pkg::NUM_LANES; gi++) begin : g_stor
			logic [1:0] spd_code;
			assign spd_code = lane_sel_r[slm_pkg::SPD_LSB + 2*gi +: 2];
			always_ff @(posedge clk) begin
				if (!reset_n) begin
					storage_speed[gi] <= slm_pkg::SPD_1G5;
					storage_pm_en[gi] <= 1'b0;
				end else if (clk_en) begin
					// reserved code falls back to top rate
					storage_speed[gi] <= (spd_code == 2'b11) ?
						slm_pkg::SPD_6G0 : slm_pkg::slm_spd_t'(spd_code);
					// one port multiplier, up to PM_MAX_DRIVES
					storage_pm_en[gi] <= lane_sel_r[slm_pkg::LOCK_BIT + 1 + gi];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// activity lamps
	// ------------------------------------------------------------
	logic [$clog2(BLINK_CYCLES)-1:0] blink_cnt_r;
	logic        blink_ph_r;
	logic [2:0]  own_stor;

	assign own_stor = {serdes_c_en.storage, serdes_b_en.storage,
		serdes_a_en.storage};

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			blink_cnt_r <= '0;
			blink_ph_r  <= 1'b0;
		end else if (clk_en) begin
			if (blink_cnt_r == ($clog2(BLINK_CYCLES))'(
				BLINK_CYCLES - 1)) begin
				blink_cnt_r <= '0;
				blink_ph_r  <= !blink_ph_r;
			end else begin
				blink_cnt_r <= blink_cnt_r + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			activity_lamp <= 3'b000;
		else if (clk_en)
			activity_lamp <= storage_busy & own_stor & {3{blink_ph_r}};
	end

	// ------------------------------------------------------------
	// hot-plug sideband routing
	// ------------------------------------------------------------
	logic [1:0] hp_sel;
	assign hp_sel = hotplug_r[slm_pkg::HP_SEL_LSB +: 2];

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			storage_presence  <= 3'b000;
			storage_switch    <= 3'b000;
			hotplug_power_out <= 1'b0;
		end else if (clk_en) begin
			// inputs from external circuitry
			for (int i = 0; i < slm_pkg::NUM_LANES; i++) begin
				storage_presence[i] <= hotplug_presence_in && hp_sel == 2'(i);
				storage_switch[i]   <= hotplug_switch_in && hp_sel == 2'(i);
			end
			// power from the selected controller or software
			hotplug_power_out <= hp_sel != 2'b11 &&
				(storage_power_req[hp_sel] || hotplug_r[slm_pkg::HP_PWR_BIT]);
		end
	end

	// ------------------------------------------------------------
	// ethernet pcs and bank ownership
	// ------------------------------------------------------------
	logic [3:0] slot_req;
	logic [3:0] slot_lim;
	assign slot_req = eth_cfg_r[slm_pkg::ETH_SLOT_LSB +: 4];

	// keep only the two lowest requested slots
	always_comb begin
		int n;
		n = 0;
		slot_lim = 4'h0;
		for (int i = 0; i < slm_pkg::QUAD_SLOTS; i++) begin
			if (slot_req[i] && n < slm_pkg::MAX_MACS) begin
				slot_lim[i] = 1'b1;
				n = n + 1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			quad_serial_route_zero <= 1'b0;
			quad_serial_route_one  <= 1'b0;
			pcs_mode               <= slm_pkg::ETH_OFF;
			quad_slot_en           <= 4'h0;
			pcs_port_speed         <= slm_pkg::ESPD_1000;
			ethernet_mac_a_serial  <= 1'b0;
			ethernet_mac_b_serial  <= 1'b0;
			bank_off               <= '0;
		end else if (clk_en) begin
			quad_serial_route_zero <= pcs_on_b;
			quad_serial_route_one  <= pcs_on_c;
			pcs_port_speed <= slm_pkg::slm_espd_t'(
				eth_cfg_r[slm_pkg::ETH_SPD_LSB +: 2]);
			if (pcs_on_b || pcs_on_c) begin
				case (emode)
				slm_pkg::ETH_QUAD: begin
					pcs_mode              <= slm_pkg::ETH_QUAD;
					quad_slot_en          <= slot_lim;
					ethernet_mac_a_serial <= 1'b1;
					ethernet_mac_b_serial <= 1'b1;
					bank_off              <= 3'b111;
				end
				slm_pkg::ETH_SINGLE: begin
					// 1.25 Gb/s single port, also on quad pcs
					pcs_mode              <= slm_pkg::ETH_SINGLE;
					quad_slot_en          <= 4'h1;
					ethernet_mac_a_serial <= !mac_b_sel;
					ethernet_mac_b_serial <= mac_b_sel;
					bank_off <= mac_b_sel ? 3'b011 : 3'b100;
				end
				default: begin
					pcs_mode              <= slm_pkg::ETH_OFF;
					quad_slot_en          <= 4'h0;
					ethernet_mac_a_serial <= 1'b0;
					ethernet_mac_b_serial <= 1'b0;
					bank_off              <= '0;
				end
				endcase
			end else begin
				pcs_mode              <= slm_pkg::ETH_OFF;
				quad_slot_en          <= 4'h0;
				ethernet_mac_a_serial <= 1'b0;
				ethernet_mac_b_serial <= 1'b0;
				bank_off              <= '0;
			end
		end
	end

	// ------------------------------------------------------------
	// status and read data
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n)
			cfg_err_r <= 1'b0;
		else if (clk_en)
			cfg_err_r <= pcs_conflict || emode == slm_pkg::ETH_RSVD;
	end

	always_ff @(posedge clk) begin
		if (!reset_n)
			avs_readdata <= slm_pkg::UNMAPPED_DATA;
		else if (clk_en && avs_read && !rd_pend_r) begin
			case (avs_address)
			slm_pkg::ADDR_LANE_SEL: avs_readdata <= lane_sel_r;
			slm_pkg::ADDR_ETH_CFG:  avs_readdata <= eth_cfg_r;
			slm_pkg::ADDR_HOTPLUG:  avs_readdata <= hotplug_r;
			slm_pkg::ADDR_STATUS:   avs_readdata <= {14'h0000,
				cfg_err_r, hotplug_power_out, hotplug_switch_in,
				hotplug_presence_in, bank_off, quad_serial_route_one,
				quad_serial_route_zero, activity_lamp, serdes_c_en,
				serdes_b_en};
			default:                avs_readdata <= slm_pkg::UNMAPPED_DATA;
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== slm_mux_asserts.sv
// checker for the shared lane selection block
// assumes it is bound onto slm_mux and sees its ports only
`default_nettype none
module slm_mux_asserts (
	input wire logic                   clk,
	input wire logic                   reset_n,
	input wire logic                   clk_en,
	input wire logic [2:0]             storage_busy,
	input wire logic                   hotplug_presence_in,
	input wire logic [2:0]             storage_presence,
	input wire slm_pkg::slm_lane_en_t  serdes_a_en,
	input wire slm_pkg::slm_lane_en_t  serdes_b_en,
	input wire slm_pkg::slm_lane_en_t  serdes_c_en,
	input wire logic                   quad_serial_route_zero,
	input wire logic                   quad_serial_route_one,
	input wire slm_pkg::slm_eth_mode_t pcs_mode,
	input wire logic [3:0]             quad_slot_en,
	input wire logic                   ethernet_mac_a_serial,
	input wire logic                   ethernet_mac_b_serial,
	input wire slm_pkg::slm_bank_t     bank_off,
	input wire logic [2:0]             activity_lamp
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	lane_a_excl_a: assert property ($onehot0(serdes_a_en) && !serdes_a_en.alt2)
		else $error("serdes a owner not exclusive");
	lane_b_excl_a: assert property ($onehot0(serdes_b_en))
		else $error("serdes b owner not exclusive");
	lane_c_excl_a: assert property ($onehot0(serdes_c_en))
		else $error("serdes c owner not exclusive");
	pcs_route_once_a: assert property (!(quad_serial_route_zero && quad_serial_route_one))
		else $error("pcs routed to two lanes");
	quad_slot_cap_a: assert property (pcs_mode == slm_pkg::ETH_QUAD |->
		$countones(quad_slot_en) <= slm_pkg::MAX_MACS)
		else $error("too many quad slots");
	quad_banks_off_a: assert property (pcs_mode == slm_pkg::ETH_QUAD |->
		bank_off == 3'b111 && ethernet_mac_a_serial && ethernet_mac_b_serial)
		else $error("quad mode left a bank on");
	mac_a_bank_a: assert property (pcs_mode == slm_pkg::ETH_SINGLE &&
		ethernet_mac_a_serial |-> bank_off == 3'b100)
		else $error("single mac a bank mismatch");
	mac_b_bank_a: assert property (pcs_mode == slm_pkg::ETH_SINGLE &&
		ethernet_mac_b_serial |-> bank_off == 3'b011)
		else $error("single mac b bank mismatch");
	lamp_busy_a: assert property (|activity_lamp && $past(clk_en) |->
		(activity_lamp & ~$past(storage_busy)) == 3'b000)
		else $error("lamp lit without transfer");
	hp_route_a: assert property (storage_presence != 3'b000 && $past(clk_en) |->
		$onehot(storage_presence) && $past(hotplug_presence_in))
		else $error("presence routed wrongly");
	lamp_owner_a: assert property (activity_lamp[1] && $past(clk_en) |->
		serdes_b_en.storage || $past(serdes_b_en.storage))
		else $error("lamp lit on foreign lane");

	cover property (pcs_mode == slm_pkg::ETH_QUAD);
	cover property (storage_presence != 3'b000);
	cover property (ethernet_mac_b_serial);
endmodule

bind slm_mux slm_mux_asserts slm_mux_asserts_inst (.clk, .reset_n, .clk_en,
	.storage_busy, .hotplug_presence_in, .storage_presence, .serdes_a_en,
	.serdes_b_en, .serdes_c_en, .quad_serial_route_zero,
	.quad_serial_route_one, .pcs_mode, .quad_slot_en, .ethernet_mac_a_serial,
	.ethernet_mac_b_serial, .bank_off, .activity_lamp);
`default_nettype wire

// ===== slm_drive_model.sv
// model of the drives and hot-plug sideband circuitry
// assumes the bench commands it; pins move one edge after a command
`default_nettype none
module slm_drive_model (
	input  wire logic       clk,
	input  wire logic       insert_cmd,
	input  wire logic       bay_cmd,
	input  wire logic [2:0] xfer_cmd,
	output logic            hotplug_presence_in,
	output logic            hotplug_switch_in,
	output logic [2:0]      storage_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		hotplug_presence_in = 1'b0;
		hotplug_switch_in = 1'b0;
		storage_busy = 3'b000;
	end
	always @(posedge clk) begin
		hotplug_presence_in <= insert_cmd;
		hotplug_switch_in <= bay_cmd;
		storage_busy <= xfer_cmd;
	end
endmodule
`default_nettype wire

// ===== slm_mux_tb.sv
// self-checking bench for the shared lane selection block
// assumes slm_mux, its checker and the drive model are compiled first
`default_nettype none
module slm_mux_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, reset_n, clk_en, avs_read, avs_write, avs_waitrequest;
	logic [3:0] avs_address, avs_byteenable, quad_slot_en;
	logic [31:0] avs_writedata, avs_readdata, d;
	logic [2:0] storage_busy, storage_presence, storage_switch;
	logic [2:0] storage_power_req, storage_pm_en, activity_lamp, xfer_cmd;
	logic hotplug_presence_in, hotplug_switch_in, hotplug_power_out;
	logic insert_cmd, bay_cmd, ethernet_mac_a_serial, ethernet_mac_b_serial;
	logic quad_serial_route_zero, quad_serial_route_one;
	slm_pkg::slm_lane_en_t serdes_a_en, serdes_b_en, serdes_c_en;
	slm_pkg::slm_spd_t [2:0] storage_speed;
	slm_pkg::slm_eth_mode_t pcs_mode;
	slm_pkg::slm_espd_t pcs_port_speed;
	slm_pkg::slm_bank_t bank_off;
	int errors = 0;
	int n_tests = 0;
	int lit = 0;
	logic [1:0] cb, cc;
	logic [2:0] e;

	slm_mux #(.BLINK_CYCLES(4)) slm_mux_inst (.clk, .reset_n, .clk_en,
		.avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .storage_busy, .hotplug_presence_in,
		.hotplug_switch_in, .hotplug_power_out, .storage_presence,
		.storage_switch, .storage_power_req, .serdes_a_en, .serdes_b_en,
		.serdes_c_en, .storage_speed, .storage_pm_en, .quad_serial_route_zero,
		.quad_serial_route_one, .pcs_mode, .quad_slot_en, .pcs_port_speed,
		.ethernet_mac_a_serial, .ethernet_mac_b_serial, .bank_off,
		.activity_lamp);
	slm_drive_model slm_drive_model_inst (.clk, .insert_cmd, .bay_cmd,
		.xfer_cmd, .hotplug_presence_in, .hotplug_switch_in, .storage_busy);

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		n_tests++;
		if (s !== x) begin
			errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, s, x);
		end
	endtask
	task automatic bus(input logic rw, input logic [3:0] a, input logic [31:0] w);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= w;
		avs_read <= rw;
		avs_write <= !rw;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic eth(input logic [1:0] m, input logic mac, input logic [3:0] sl,
		input logic [1:0] sp, input logic [2:0] bk, input logic [3:0] se);
		bus(1'b0, slm_pkg::ADDR_ETH_CFG, {22'h0, sp, sl, 1'b0, mac, m});
		chk(pcs_mode, m);
		chk(bank_off, bk);
		chk({ethernet_mac_a_serial, ethernet_mac_b_serial}, {bk[2], bk[0]});
		if (m == 2'b10) begin
			chk(quad_slot_en, se);
			chk(pcs_port_speed, sp);
		end
	endtask
	task automatic wrap_up;
		$display("errors %0d of %0d checks", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// clock, watchdog and tests
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		wrap_up;
	end
	initial begin
		{reset_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
		{storage_power_req, insert_cmd, bay_cmd, xfer_cmd} = '0;
		clk_en = 1'b1;
		avs_byteenable = 4'hf;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		chk({serdes_a_en, serdes_b_en, serdes_c_en, bank_off}, 0);
		bus(1'b0, slm_pkg::ADDR_ETH_CFG, 32'h0000_0001);
		for (int i = 0; i < 4; i++) begin
			cb = 2'(i);
			cc = 2'(i + 1);
			bus(1'b0, slm_pkg::ADDR_LANE_SEL, {26'h0, cc, cb, cb});
			chk(serdes_a_en, i == 0 ? 3'b100 : i == 1 ? 3'b010 : 3'b000);
			chk(serdes_b_en, i == 3 ? 3'b000 : 3'b100 >> i);
			chk(serdes_c_en, cc == 3 ? 3'b000 : 3'b100 >> cc);
			chk({quad_serial_route_zero, quad_serial_route_one}, {cb == 2, cc == 2});
			bus(1'b1, slm_pkg::ADDR_LANE_SEL, 0);
			chk(d[5:0], {cc, cb, cb});
		end
		bus(1'b0, slm_pkg::ADDR_LANE_SEL, 32'h0000_0028);
		chk({quad_serial_route_zero, quad_serial_route_one}, 2'b10);
		bus(1'b1, slm_pkg::ADDR_STATUS, 0);
		chk(d[17:9], 9'h111);
		eth(2'd0, 1'b0, 4'h0, 2'd0, 3'b000, 4'h0);
		eth(2'd1, 1'b0, 4'h0, 2'd0, 3'b100, 4'h0);
		eth(2'd1, 1'b1, 4'h0, 2'd0, 3'b011, 4'h0);
		for (int j = 0; j < 3; j++)
			eth(2'd2, 1'b0, 4'hf, 2'(j), 3'b111, 4'h3);
		eth(2'd2, 1'b0, 4'ha, 2'd2, 3'b111, 4'ha);
		insert_cmd <= 1'b1;
		bay_cmd <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			bus(1'b0, slm_pkg::ADDR_HOTPLUG, 32'(k));
			e = k == 3 ? 3'b000 : 3'b001 << k;
			chk({storage_presence, storage_switch}, {e, e});
			storage_power_req <= e;
			repeat (3) @(posedge clk);
			chk(hotplug_power_out, k != 3);
			storage_power_req <= ~e;
			repeat (3) @(posedge clk);
			chk(hotplug_power_out, 1'b0);
		end
		bus(1'b0, slm_pkg::ADDR_LANE_SEL, 32'h0039_0400);
		chk(storage_speed, 6'h29);
		chk(storage_pm_en, 3'h2);
		bus(1'b0, slm_pkg::ADDR_LANE_SEL, 32'h0000_0004);
		xfer_cmd <= 3'b111;
		repeat (8) @(posedge clk);
		chk(activity_lamp[1], 1'b0);
		repeat (16) begin
			@(posedge clk);
			lit += activity_lamp[0] + activity_lamp[2];
		end
		chk(lit, 16);
		clk_en <= 1'b0;
		@(posedge clk);
		d = 32'(activity_lamp);
		repeat (4) @(posedge clk);
		chk(activity_lamp, d[2:0]);
		clk_en <= 1'b1;
		bus(1'b1, 4'h2, 0);
		chk(d, slm_pkg::UNMAPPED_DATA);
		bus(1'b0, slm_pkg::ADDR_LANE_SEL, 32'h0000_0100);
		bus(1'b0, slm_pkg::ADDR_LANE_SEL, 32'h0000_0001);
		chk(serdes_a_en, 3'b100);
		reset_n <= 1'b0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		bus(1'b0, slm_pkg::ADDR_LANE_SEL, 32'h0000_0001);
		chk(serdes_a_en, 3'b010);
		wrap_up;
	end
endmodule
`default_nettype wire
